// ### chr_defines.svh
// Constants for the charger input and power-path control block
`ifndef CHR_DEFINES_SVH
`define CHR_DEFINES_SVH
// Register offsets
`define CHR_A_CTRL    4'h0
`define CHR_A_EXTERNAL_RESISTOR_LIMIT    4'h1
`define CHR_A_VLIM    4'h2
`define CHR_A_OPT     4'h3
`define CHR_A_BOOST   4'h4
`define CHR_A_BOOST_VOLTAGE_SETTING  4'h5
`define CHR_A_SYSMIN  4'h6
`define CHR_A_STAT    4'h7
`define CHR_A_OPTRES  4'h8
// Control, optimizer and boost register bit positions
`define CHR_B_HIZ     0
`define CHR_B_FDET    1
`define CHR_B_AUTO    2
`define CHR_B_ABS     3
`define CHR_B_CHG     4
`define CHR_B_RLIM    5
`define CHR_B_OPTEN   0
`define CHR_B_FOPT    1
`define CHR_B_BCFG    0
`define CHR_B_BFREQ   1
// Reset values
`define CHR_R_CTRL    8'h34
`define CHR_R_OPT     8'h01
`define CHR_R_BOOST   8'h00
`define CHR_R_BOOST_VOLTAGE_SETTING  4'h7
`define CHR_R_SYSMIN  3'h5
`define CHR_R_VLIM    8'h00
// Current codes, 50 mA per step above 100 mA
`define CHR_I_500MA   6'h08
`define CHR_I_3250MA  6'h3f
`define CHR_I_200MA   6'h02
`define CHR_I_MAX     6'h3f
// Source type codes
`define CHR_T_NONE    3'h0
`define CHR_T_USB     3'h1
`define CHR_T_ADAPT   3'h2
`define CHR_T_BOOST   3'h7
// Boost start delay
`define CHR_CLK_NS     10
`define CHR_BOOST_MS   30
`define CHR_BOOST_CYC  ((`CHR_BOOST_MS * 1000000) / `CHR_CLK_NS)
`endif

// ### chr_pkg.sv
// Types shared by the charger control block
package chr_pkg;
	// Input-side power-up sequence
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DETECT,
		ST_VLIM,
		ST_RUN
	} chr_state_t;
endpackage : chr_pkg

// ### chr_sync.sv
// Two-flop synchroniser for a bank of comparator levels
`timescale 1ns/1ps
module chr_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_sys_i,
	input  wire logic         sys_rst_i,
	// Levels
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] stage1; // First stage, read only by second stage

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			// Each bit has its own pair of flops
			always_ff @(posedge clk_sys_i) begin
				if (sys_rst_i) begin
					stage1[g] <= 1'b0;
					sync_o[g] <= 1'b0;
				end else begin
					stage1[g] <= async_i[g];
					sync_o[g] <= stage1[g];
				end
			end
		end
	endgenerate
endmodule : chr_sync

// ### chr_ctrl.sv
// Charger input detection, power-up, boost and power-path control
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "chr_defines.svh"
module chr_ctrl
	import chr_pkg::*;
#(
	parameter int unsigned BOOST_DELAY_CYC = `CHR_BOOST_CYC
) (
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       sys_rst_i,
	// Register port
	input  wire logic [3:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_we_i,
	input  wire logic       reg_re_i,
	output logic      [7:0] reg_rdata_o,
	// Comparator and pin levels
	input  wire logic       port_select_i,
	input  wire logic       boost_request_pin_i,
	input  wire logic       input_good_i,
	input  wire logic       sys_above_2v2_i,
	input  wire logic       bat_above_lowv_i,
	input  wire logic       vbus_below_sleep_i,
	input  wire logic       ts_boost_ok_i,
	input  wire logic       bat_above_boost_i,
	input  wire logic       bat_below_sysmin_i,
	input  wire logic       sys_at_min_i,
	input  wire logic       in_over_current_i,
	input  wire logic       in_under_voltage_i,
	input  wire logic       sys_below_bat_i,
	input  wire logic       bat_below_deplete_i,
	// Analog helper results, quasi-static codes
	input  wire logic       vlim_algo_done_i,
	input  wire logic [7:0] vlim_algo_value_i,
	input  wire logic       optimizer_done_i,
	input  wire logic [5:0] optimizer_value_i,
	input  wire logic [5:0] external_resistor_limit_i,
	// Control outputs
	output logic            irq_pulse_o,
	output logic            converter_enable_o,
	output logic            high_impedance_o,
	output logic            battery_switch_o,
	output logic            pfm_select_o,
	output logic      [5:0] applied_limit_o,
	output logic      [7:0] voltage_limit_o,
	output logic            charge_reduce_o,
	output logic            optimizer_run_o,
	output logic            boost_enable_o,
	output logic            boost_frequency_o,
	output logic      [2:0] boost_current_limit_o,
	output logic      [3:0] boost_voltage_o
);
	// Synchronised comparator levels
	logic s_psel, s_breq, s_good, s_2v2, s_lowv, s_sleep, s_ts, s_bbat;
	logic s_sysmin, s_atmin, s_oc, s_uv, s_sbb, s_dep, s_vdone, s_odone;

	// Software registers
	logic [7:0] ctrl;                        // Control flags
	logic [5:0] input_current_limit_setting; // Programmed input limit
	logic [7:0] input_voltage_limit;         // Voltage limit threshold
	logic [1:0] opt;                         // Optimizer enable and force
	logic [4:0] boost;                       // Config, frequency, current
	logic [3:0] boost_voltage_setting;       // Boost output voltage code
	logic [2:0] minimum_system_voltage;      // Minimum system code

	// Status
	logic [2:0]  source_type_code;
	logic        detection_done_flag;
	logic [5:0]  optimizer_result_limit;
	logic        supplement;                 // Supplement mode active
	logic        boost_active;
	logic [31:0] boost_cnt;                  // Boost start delay counter
	logic        good_q;                     // Previous input-good level
	chr_state_t  state;
	chr_state_t  next_state;

	// Synchronise every comparator before use
	chr_sync #(
		.W (16)
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.async_i   ({port_select_i, boost_request_pin_i, input_good_i, sys_above_2v2_i,
		              bat_above_lowv_i, vbus_below_sleep_i, ts_boost_ok_i, bat_above_boost_i,
		              bat_below_sysmin_i, sys_at_min_i, in_over_current_i, in_under_voltage_i,
		              sys_below_bat_i, bat_below_deplete_i, vlim_algo_done_i, optimizer_done_i}),
		.sync_o    ({s_psel, s_breq, s_good, s_2v2, s_lowv, s_sleep, s_ts, s_bbat,
		              s_sysmin, s_atmin, s_oc, s_uv, s_sbb, s_dep, s_vdone, s_odone})
	);

	// Register write decode
	wire wr_ctrl   = reg_we_i && (reg_addr_i == `CHR_A_CTRL);
	wire wr_external_resistor_limit   = reg_we_i && (reg_addr_i == `CHR_A_EXTERNAL_RESISTOR_LIMIT);
	wire wr_vlim   = reg_we_i && (reg_addr_i == `CHR_A_VLIM);
	wire wr_opt    = reg_we_i && (reg_addr_i == `CHR_A_OPT);
	wire wr_boost  = reg_we_i && (reg_addr_i == `CHR_A_BOOST);
	wire wr_boost_voltage_setting = reg_we_i && (reg_addr_i == `CHR_A_BOOST_VOLTAGE_SETTING);
	wire wr_sysmin = reg_we_i && (reg_addr_i == `CHR_A_SYSMIN);

	// Named control fields
	wire hiz_req   = ctrl[`CHR_B_HIZ];
	wire force_det = ctrl[`CHR_B_FDET];
	wire auto_det  = ctrl[`CHR_B_AUTO];
	wire abs_sel   = ctrl[`CHR_B_ABS];
	wire chg_en    = ctrl[`CHR_B_CHG];
	wire rlim_en   = ctrl[`CHR_B_RLIM];
	wire opt_en    = opt[`CHR_B_OPTEN];
	wire force_opt = opt[`CHR_B_FOPT];
	wire boost_cfg = boost[`CHR_B_BCFG];

	// Sequence events
	wire plug_in    = s_good && !good_q;
	wire input_live = s_good && !hiz_req;
	wire det_done   = (state == ST_DETECT);
	wire vlim_done  = (state == ST_VLIM) && (abs_sel || s_vdone);
	wire [2:0] det_type = s_psel ? `CHR_T_USB : `CHR_T_ADAPT; // Full code width, adapter code has bit 0 clear

	// Adapter detection is the only case that starts the optimizer by itself
	wire opt_auto   = det_done && opt_en && !s_psel;
	wire opt_start  = opt_auto || force_opt;

	// Boost start qualifiers, all must hold together
	wire boost_ok   = s_lowv && s_sleep && s_breq && boost_cfg && s_ts && s_bbat;
	wire boost_fire = boost_ok && (boost_cnt >= BOOST_DELAY_CYC - 1);

	// Input current limit selection
	wire [5:0] prog_lim  = opt_en ? optimizer_result_limit : input_current_limit_setting;
	wire [5:0] ext_lim   = rlim_en ? external_resistor_limit_i : `CHR_I_MAX;
	wire [5:0] soft_lim  = (input_current_limit_setting < `CHR_I_200MA) ?
	                       input_current_limit_setting : `CHR_I_200MA;
	wire [5:0] base_lim  = s_2v2 ? prog_lim : soft_lim;
	wire [5:0] next_lim  = (base_lim < ext_lim) ? base_lim : ext_lim;

	// Sequence next state
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				// Detection is bypassed when automatic detection is off
				if (plug_in && !hiz_req) begin
					next_state = auto_det ? ST_DETECT : ST_VLIM;
				end
			end
			ST_DETECT: begin
				next_state = ST_VLIM;
			end
			ST_VLIM: begin
				if (vlim_done) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				// Forced detection reruns the classification
				if (force_det) begin
					next_state = ST_DETECT;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// Losing the input or entering high impedance stops the converter
		if (!input_live) begin
			next_state = ST_IDLE;
		end
	end

	// Sequence state register
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state  <= ST_IDLE;
			good_q <= 1'b0;
		end else begin
			state  <= next_state;
			good_q <= s_good;
		end
	end

	// Control register; hardware clear of the force-detect bit loses to a host set
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ctrl <= `CHR_R_CTRL;
		end else if (wr_ctrl) begin
			ctrl <= reg_wdata_i;
		end else if (det_done) begin
			ctrl[`CHR_B_FDET] <= 1'b0;
		end
	end

	// Input current limit setting, written by host or by detection
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			input_current_limit_setting <= `CHR_I_500MA;
		end else if (wr_external_resistor_limit) begin
			input_current_limit_setting <= reg_wdata_i[5:0];
		end else if (det_done) begin
			input_current_limit_setting <= s_psel ? `CHR_I_500MA : `CHR_I_3250MA;
		end
	end

	// Detection results; untouched when detection is skipped
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			detection_done_flag <= 1'b0;
			source_type_code    <= `CHR_T_NONE;
		end else if (det_done) begin
			detection_done_flag <= 1'b1;
			source_type_code    <= det_type;
		end
	end

	// Voltage limit: host owns it only in absolute mode
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			input_voltage_limit <= `CHR_R_VLIM;
		end else if (abs_sel) begin
			if (wr_vlim) begin
				input_voltage_limit <= reg_wdata_i;
			end
		end else if ((state == ST_VLIM) && s_vdone) begin
			input_voltage_limit <= vlim_algo_value_i;
		end
	end

	// Optimizer control; force bit clears when the run ends unless rewritten
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			opt <= 2'(`CHR_R_OPT);
		end else if (wr_opt) begin
			opt <= reg_wdata_i[1:0];
		end else if (optimizer_run_o && s_odone) begin
			opt[`CHR_B_FOPT] <= 1'b0;
		end
	end

	// Optimizer run flag and captured result
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			optimizer_run_o        <= 1'b0;
			optimizer_result_limit <= `CHR_I_500MA;
		end else if (optimizer_run_o && s_odone) begin
			optimizer_run_o        <= 1'b0;
			optimizer_result_limit <= optimizer_value_i;
		end else if (opt_start && input_live) begin
			optimizer_run_o        <= 1'b1;
		end
	end

	// Boost frequency frozen while boost is configured
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			boost <= 5'(`CHR_R_BOOST);
		end else if (wr_boost) begin
			boost[`CHR_B_BCFG] <= reg_wdata_i[`CHR_B_BCFG];
			boost[4:2]         <= reg_wdata_i[4:2];
			if (!boost_cfg) begin
				boost[`CHR_B_BFREQ] <= reg_wdata_i[`CHR_B_BFREQ];
			end
		end
	end

	// Boost voltage and minimum system settings
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			boost_voltage_setting  <= `CHR_R_BOOST_VOLTAGE_SETTING;
			minimum_system_voltage <= `CHR_R_SYSMIN;
		end else begin
			if (wr_boost_voltage_setting) begin
				boost_voltage_setting <= reg_wdata_i[3:0];
			end
			if (wr_sysmin) begin
				minimum_system_voltage <= reg_wdata_i[2:0];
			end
		end
	end

	// Boost delay and run; any lost qualifier restarts the delay
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			boost_cnt    <= 32'h0;
			boost_active <= 1'b0;
		end else if (!boost_ok) begin
			boost_cnt    <= 32'h0;
			boost_active <= 1'b0;
		end else if (!boost_active) begin
			boost_cnt    <= boost_cnt + 32'h1;
			boost_active <= boost_fire;
		end
	end

	// Supplement mode: on when system sags below battery, off at depletion
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			supplement <= 1'b0;
		end else if (s_dep) begin
			supplement <= 1'b0;
		end else if (s_sbb) begin
			supplement <= 1'b1;
		end
	end

	// Power stage outputs
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			converter_enable_o <= 1'b0;
			high_impedance_o   <= 1'b0;
			battery_switch_o   <= 1'b0;
			pfm_select_o       <= 1'b0;
			applied_limit_o    <= `CHR_I_200MA;
			voltage_limit_o    <= `CHR_R_VLIM;
			charge_reduce_o    <= 1'b0;
		end else begin
			converter_enable_o <= (state == ST_RUN);
			high_impedance_o   <= hiz_req;
			// Battery carries the system without input unless depleted
			battery_switch_o   <= supplement || ((state == ST_RUN) ? chg_en : !s_dep);
			pfm_select_o       <= s_sysmin || !chg_en;
			applied_limit_o    <= next_lim;
			voltage_limit_o    <= input_voltage_limit;
			charge_reduce_o    <= s_oc || s_uv;
		end
	end

	// Boost outputs
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			boost_enable_o        <= 1'b0;
			boost_frequency_o     <= 1'b0;
			boost_current_limit_o <= 3'h0;
			boost_voltage_o       <= `CHR_R_BOOST_VOLTAGE_SETTING;
		end else begin
			boost_enable_o        <= boost_active;
			boost_frequency_o     <= boost[`CHR_B_BFREQ];
			boost_current_limit_o <= boost[4:2];
			boost_voltage_o       <= boost_voltage_setting;
		end
	end

	// Interrupt pulse after detection and after the voltage limit settles
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			irq_pulse_o <= 1'b0;
		end else begin
			irq_pulse_o <= det_done || vlim_done;
		end
	end

	// Read data mux; unmapped offsets read zero
	wire [2:0] type_rd = boost_active ? `CHR_T_BOOST : source_type_code;
	wire [7:0] stat_rd = {boost_active, s_oc, s_uv, s_atmin, detection_done_flag, type_rd};
	wire [7:0] rd_mux  = (reg_addr_i == `CHR_A_CTRL)   ? ctrl :
	                     (reg_addr_i == `CHR_A_EXTERNAL_RESISTOR_LIMIT)   ? {2'h0, input_current_limit_setting} :
	                     (reg_addr_i == `CHR_A_VLIM)   ? input_voltage_limit :
	                     (reg_addr_i == `CHR_A_OPT)    ? {6'h0, opt} :
	                     (reg_addr_i == `CHR_A_BOOST)  ? {3'h0, boost} :
	                     (reg_addr_i == `CHR_A_BOOST_VOLTAGE_SETTING) ? {4'h0, boost_voltage_setting} :
	                     (reg_addr_i == `CHR_A_SYSMIN) ? {5'h0, minimum_system_voltage} :
	                     (reg_addr_i == `CHR_A_STAT)   ? stat_rd :
	                     (reg_addr_i == `CHR_A_OPTRES) ? {2'h0, optimizer_result_limit} : 8'h00;

	// Read data registered one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			reg_rdata_o <= reg_re_i ? rd_mux : 8'h00;
		end
	end
endmodule : chr_ctrl

// ### chr_ctrl_sva.sv
// Port-level assertions for the charger control block
`timescale 1ns/1ps
`include "chr_defines.svh"
module chr_ctrl_sva #(
	parameter int unsigned BOOST_DELAY_CYC = 20
) (
	// Clock and reset
	input wire logic       clk_sys_i,
	input wire logic       sys_rst_i,
	// Register port
	input wire logic       reg_re_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_we_i,
	input wire logic [7:0] reg_rdata_o,
	// Pin and comparator levels
	input wire logic       boost_request_pin_i,
	input wire logic       sys_above_2v2_i,
	input wire logic       bat_above_lowv_i,
	input wire logic       vbus_below_sleep_i,
	input wire logic       ts_boost_ok_i,
	input wire logic       bat_above_boost_i,
	input wire logic       bat_below_sysmin_i,
	input wire logic       in_over_current_i,
	input wire logic       bat_below_deplete_i,
	// Control outputs
	input wire logic       irq_pulse_o,
	input wire logic       converter_enable_o,
	input wire logic       battery_switch_o,
	input wire logic       pfm_select_o,
	input wire logic [5:0] applied_limit_o,
	input wire logic       charge_reduce_o,
	input wire logic       boost_enable_o
);
	wire logic   all_qual; // Every boost qualifier high at the pins
	int unsigned qual_cnt; // Unbroken run of all_qual, saturating
	logic        chg_shadow; // Charge enable as last written by the host
	// Charging in run keeps the battery switch on, so the depletion check needs this bit
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			chg_shadow <= 1'(`CHR_R_CTRL >> `CHR_B_CHG);
		end else if (reg_we_i && (reg_addr_i == `CHR_A_CTRL)) begin
			chg_shadow <= reg_wdata_i[`CHR_B_CHG];
		end
	end
	assign all_qual = bat_above_lowv_i & vbus_below_sleep_i & boost_request_pin_i & ts_boost_ok_i & bat_above_boost_i;
	// Any dropout restarts the count, as it restarts the start delay
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || !all_qual) begin
			qual_cnt <= 0;
		end else if (qual_cnt < BOOST_DELAY_CYC) begin
			qual_cnt <= qual_cnt + 1;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// Detection pulse followed by threshold pulse
	sequence s_irq_pair;
		irq_pulse_o ##1 irq_pulse_o;
	endsequence
	a_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	a_irq_burst: assert property (s_irq_pair |=> !irq_pulse_o)
		else $error("more than two event pulses in a row");
	a_conv_after_irq: assert property ($rose(converter_enable_o) |-> $past(irq_pulse_o))
		else $error("converter started without a preceding event pulse");
	a_low_rail_limit: assert property (!sys_above_2v2_i [*5] |=> applied_limit_o <= 6'h02)
		else $error("input limit above 200 mA on a low rail");
	a_pfm_low_bat: assert property (bat_below_sysmin_i [*5] |=> pfm_select_o)
		else $error("light-load mode missing with low battery");
	a_boost_delay: assert property ($rose(boost_enable_o) |-> qual_cnt >= BOOST_DELAY_CYC)
		else $error("boost started before the start delay");
	a_boost_stop: assert property (!bat_above_boost_i [*6] |=> !boost_enable_o)
		else $error("boost kept running on a weak battery");
	a_reduce_overload: assert property (in_over_current_i [*5] |=> charge_reduce_o)
		else $error("charge current not reduced on overload");
	a_deplete_off: assert property ((bat_below_deplete_i && !chg_shadow) [*5] |=> !battery_switch_o)
		else $error("battery switch on with depleted battery");
endmodule : chr_ctrl_sva

bind chr_ctrl chr_ctrl_sva #(.BOOST_DELAY_CYC(BOOST_DELAY_CYC)) chr_ctrl_sva_inst (.clk_sys_i, .sys_rst_i, .reg_re_i,
	.reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_rdata_o, .boost_request_pin_i, .sys_above_2v2_i, .bat_above_lowv_i,
	.vbus_below_sleep_i, .ts_boost_ok_i, .bat_above_boost_i, .bat_below_sysmin_i, .in_over_current_i,
	.bat_below_deplete_i, .irq_pulse_o, .converter_enable_o, .battery_switch_o, .pfm_select_o, .applied_limit_o,
	.charge_reduce_o, .boost_enable_o);

// ### chr_src_model.sv
// Behavioural source side: plug, PHY select and analog helper results
`timescale 1ns/1ps
module chr_src_model #(
	parameter int         VLIM_DLY = 10,
	parameter logic [7:0] VLIM_VAL = 8'h5a,
	parameter int         OPT_DLY  = 12,
	parameter logic [5:0] OPT_VAL  = 6'h20
) (
	// Clock
	input  wire logic       clk_sys_i,
	// Bench controls
	input  wire logic       plug_i,
	input  wire logic       usb_host_i,
	input  wire logic       optimizer_run_i,
	// Source side levels
	output logic            input_good_o,
	output logic            port_select_o,
	output logic            vlim_done_o,
	output logic      [7:0] vlim_value_o,
	output logic            opt_done_o,
	output logic      [5:0] opt_value_o
);
	int vlim_cnt = 0; // Cycles since the source appeared
	int opt_cnt  = 0; // Cycles the optimizer has been running
	// PHY reports host port high, charging port low
	assign input_good_o  = plug_i;
	assign port_select_o = usb_host_i;
	// Results show the inverse until done, so an early latch is caught
	assign vlim_value_o = vlim_done_o ? VLIM_VAL : ~VLIM_VAL;
	assign opt_value_o  = opt_done_o ? OPT_VAL : ~OPT_VAL;
	assign vlim_done_o  = plug_i && (vlim_cnt >= VLIM_DLY);
	assign opt_done_o   = optimizer_run_i && (opt_cnt >= OPT_DLY);
	// Both helpers restart whenever their trigger drops
	always_ff @(posedge clk_sys_i) begin
		vlim_cnt <= plug_i ? vlim_cnt + 1 : 0;
		opt_cnt  <= optimizer_run_i ? opt_cnt + 1 : 0;
	end
endmodule : chr_src_model

// ### chr_ctrl_bench.sv
// Register-driven testbench for the charger control block
`timescale 1ns/1ps
`include "chr_defines.svh"
module chr_ctrl_bench;
	localparam int BOOST_DLY = 20; // Shortened start delay
	logic       clk_sys_i, sys_rst_i, reg_we_i, reg_re_i, plug, usb_host;
	logic [3:0] reg_addr_i, boost_voltage_o;
	logic [7:0] reg_wdata_i, reg_rdata_o, vlim_algo_value_i, voltage_limit_o;
	logic       port_select_i, boost_request_pin_i, input_good_i, sys_above_2v2_i, bat_above_lowv_i;
	logic       vbus_below_sleep_i, ts_boost_ok_i, bat_above_boost_i, bat_below_sysmin_i, sys_at_min_i;
	logic       in_over_current_i, in_under_voltage_i, sys_below_bat_i, bat_below_deplete_i, vlim_algo_done_i;
	logic       optimizer_done_i, irq_pulse_o, converter_enable_o, high_impedance_o, battery_switch_o;
	logic       pfm_select_o, charge_reduce_o, optimizer_run_o, boost_enable_o, boost_frequency_o;
	logic [5:0] optimizer_value_i, external_resistor_limit_i, applied_limit_o;
	logic [2:0] boost_current_limit_o;
	int         num_errors, checks_done, irq_cnt, cyc, t0;
	logic [7:0] rst_tab [10] = '{8'h34, 8'h08, 8'h00, 8'h01, 8'h00, 8'h07, 8'h05, 8'h00, 8'h08, 8'h00};
	chr_ctrl #(.BOOST_DELAY_CYC(BOOST_DLY)) chr_ctrl_inst (.clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
		.reg_we_i, .reg_re_i, .reg_rdata_o, .port_select_i, .boost_request_pin_i, .input_good_i, .sys_above_2v2_i,
		.bat_above_lowv_i, .vbus_below_sleep_i, .ts_boost_ok_i, .bat_above_boost_i, .bat_below_sysmin_i,
		.sys_at_min_i, .in_over_current_i, .in_under_voltage_i, .sys_below_bat_i, .bat_below_deplete_i,
		.vlim_algo_done_i, .vlim_algo_value_i, .optimizer_done_i, .optimizer_value_i, .external_resistor_limit_i,
		.irq_pulse_o, .converter_enable_o, .high_impedance_o, .battery_switch_o, .pfm_select_o, .applied_limit_o,
		.voltage_limit_o, .charge_reduce_o, .optimizer_run_o, .boost_enable_o, .boost_frequency_o,
		.boost_current_limit_o, .boost_voltage_o);
	chr_src_model chr_src_model_inst (.clk_sys_i, .plug_i(plug), .usb_host_i(usb_host), .optimizer_run_i(optimizer_run_o),
		.input_good_o(input_good_i), .port_select_o(port_select_i), .vlim_done_o(vlim_algo_done_i),
		.vlim_value_o(vlim_algo_value_i), .opt_done_o(optimizer_done_i), .opt_value_o(optimizer_value_i));
	// Free-running clock, 10 ns
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// Cycle and event pulse counters
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (irq_pulse_o === 1'b1) irq_cnt <= irq_cnt + 1;
	end
	task step(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : step
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_we_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_we_i <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys_i);
		reg_re_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_re_i <= 1'b0;
		#1 chk(reg_rdata_o, exp);
	endtask : rd
	// Bounded wait for a level, then compare it
	task automatic wait_for(ref logic s, input logic v);
		int n = 0;
		while (s !== v && n < 400) begin
			@(posedge clk_sys_i);
			n++;
		end
		#1 chk(s, v);
	endtask : wait_for
	task close_out;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : close_out
	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		num_errors++;
		close_out();
	end
	initial begin
		{reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i, plug, usb_host} = '0;
		{boost_request_pin_i, sys_above_2v2_i, bat_above_lowv_i, vbus_below_sleep_i, ts_boost_ok_i} = '0;
		{bat_above_boost_i, bat_below_sysmin_i, sys_at_min_i, in_over_current_i, in_under_voltage_i} = '0;
		{sys_below_bat_i, bat_below_deplete_i} = '0;
		external_resistor_limit_i = 6'h3f;
		sys_rst_i = 1'b1;
		step(6);
		sys_rst_i <= 1'b0;
		#1 chk(applied_limit_o, 8'h02);
		chk(boost_voltage_o, 8'h07);
		chk(boost_current_limit_o, 8'h00);
		for (int i = 0; i < 10; i++) rd((i == 9) ? 4'hf : 4'(i), rst_tab[i]);
		// USB host port plugged in, automatic threshold
		@(posedge clk_sys_i) usb_host <= 1'b1;
		@(posedge clk_sys_i) plug <= 1'b1;
		wait_for(converter_enable_o, 1'b1);
		chk(irq_cnt, 8'h02);
		rd(`CHR_A_EXTERNAL_RESISTOR_LIMIT, {2'b00, `CHR_I_500MA});
		rd(`CHR_A_STAT, {5'h01, `CHR_T_USB});
		wr(`CHR_A_VLIM, 8'h33);
		rd(`CHR_A_VLIM, 8'h5a);
		chk(voltage_limit_o, 8'h5a);
		chk({battery_switch_o, optimizer_run_o, applied_limit_o}, 8'h82);
		@(posedge clk_sys_i) {sys_at_min_i, in_under_voltage_i} <= 2'b11;
		step(6);
		rd(`CHR_A_STAT, 8'h39);
		chk(charge_reduce_o, 1'b1);
		@(posedge clk_sys_i) {sys_at_min_i, in_under_voltage_i, in_over_current_i} <= 3'b001;
		step(6);
		rd(`CHR_A_STAT, 8'h49);
		@(posedge clk_sys_i) {in_over_current_i, sys_above_2v2_i, external_resistor_limit_i} <= {2'b01, 6'h05};
		step(6);
		chk({charge_reduce_o, pfm_select_o, applied_limit_o}, 8'h05);
		wr(`CHR_A_CTRL, 8'h14);
		step(3);
		chk(applied_limit_o, 8'h08);
		// Charging off, then supplement entry and exit
		wr(`CHR_A_CTRL, 8'h04);
		step(3);
		chk({battery_switch_o, pfm_select_o}, 8'h01);
		@(posedge clk_sys_i) {sys_below_bat_i, bat_below_sysmin_i} <= 2'b11;
		step(6);
		chk(battery_switch_o, 1'b1);
		@(posedge clk_sys_i) bat_below_deplete_i <= 1'b1;
		step(6);
		chk(battery_switch_o, 1'b0);
		@(posedge clk_sys_i) {sys_below_bat_i, bat_below_deplete_i, bat_below_sysmin_i} <= 3'b000;
		wr(`CHR_A_CTRL, 8'h35);
		step(3);
		chk({high_impedance_o, converter_enable_o}, 8'h02);
		// Adapter with host-owned threshold, optimizer starts by itself
		@(posedge clk_sys_i) {plug, usb_host, external_resistor_limit_i} <= {2'b00, 6'h3f};
		step(6);
		wr(`CHR_A_CTRL, 8'h3c);
		wr(`CHR_A_VLIM, 8'h44);
		rd(`CHR_A_VLIM, 8'h44);
		chk(voltage_limit_o, 8'h44);
		@(posedge clk_sys_i) plug <= 1'b1;
		wait_for(optimizer_run_o, 1'b1);
		wait_for(optimizer_run_o, 1'b0);
		wait_for(converter_enable_o, 1'b1);
		rd(`CHR_A_EXTERNAL_RESISTOR_LIMIT, {2'b00, `CHR_I_3250MA});
		rd(`CHR_A_STAT, {5'h01, `CHR_T_ADAPT});
		rd(`CHR_A_OPTRES, 8'h20);
		chk(applied_limit_o, 8'h20);
		wr(`CHR_A_OPT, 8'h00);
		step(3);
		chk(applied_limit_o, 8'h3f);
		// Forced detection on a host port, then forced optimizer
		@(posedge clk_sys_i) usb_host <= 1'b1;
		step(4);
		wr(`CHR_A_CTRL, 8'h3e);
		step(10);
		rd(`CHR_A_CTRL, 8'h3c);
		rd(`CHR_A_EXTERNAL_RESISTOR_LIMIT, {2'b00, `CHR_I_500MA});
		rd(`CHR_A_STAT, {5'h01, `CHR_T_USB});
		wr(`CHR_A_OPT, 8'h03);
		wait_for(optimizer_run_o, 1'b1);
		wait_for(optimizer_run_o, 1'b0);
		rd(`CHR_A_OPT, 8'h01);
		// Replug with automatic detection off keeps old results
		wr(`CHR_A_CTRL, 8'h38);
		@(posedge clk_sys_i) {plug, usb_host} <= 2'b00;
		step(6);
		@(posedge clk_sys_i) plug <= 1'b1;
		wait_for(converter_enable_o, 1'b1);
		rd(`CHR_A_EXTERNAL_RESISTOR_LIMIT, {2'b00, `CHR_I_500MA});
		rd(`CHR_A_STAT, {5'h01, `CHR_T_USB});
		// Boost from battery
		@(posedge clk_sys_i) plug <= 1'b0;
		wr(`CHR_A_BOOST, 8'h02);
		wr(`CHR_A_BOOST, 8'h03);
		wr(`CHR_A_BOOST, 8'h1d);
		wr(`CHR_A_BOOST_VOLTAGE_SETTING, 8'h03);
		step(2);
		chk({boost_frequency_o, boost_current_limit_o, boost_voltage_o}, 8'hf3);
		@(posedge clk_sys_i) begin
			{bat_above_lowv_i, vbus_below_sleep_i, boost_request_pin_i, ts_boost_ok_i, bat_above_boost_i} <= 5'h1f;
			t0 = cyc;
		end
		wait_for(boost_enable_o, 1'b1);
		chk({7'h00, (cyc - t0) >= BOOST_DLY}, 8'h01);
		rd(`CHR_A_STAT, {5'h11, `CHR_T_BOOST});
		@(posedge clk_sys_i) bat_above_boost_i <= 1'b0;
		step(8);
		chk(boost_enable_o, 1'b0);
		close_out();
	end
endmodule : chr_ctrl_bench
